// [hdl/deg_jog_defines.vh]
`ifndef DEG_JOG_DEFINES_VH
`define DEG_JOG_DEFINES_VH
// ****************
// register byte offsets
// ****************
`define REG_CTRL 8'h00
`define REG_JOG_SPEED 8'h04
`define REG_PT1_ACCEL 8'h08
`define REG_PT1_DECEL 8'h0C
`define REG_AUTO_DIST 8'h10
`define REG_AUTO_SPEED 8'h14
`define REG_AUTO_ACCEL 8'h18
`define REG_AUTO_DECEL 8'h1C
`define REG_LIMIT_BASE 8'h20
`define REG_LIMIT_LAST 8'h3C
`define REG_STATUS 8'h40
`define REG_POSITION 8'h44
`define REG_REMAIN 8'h48
// ****************
// field positions
// ****************
`define CTRL_ROT_DIR_BIT 0
`define ST_MOVING_BIT 0
`define ST_PAUSED_BIT 1
`define ST_LIMIT_BIT 2
`define ST_IN_RANGE_BIT 3
`define ST_MANUAL_BIT 4
`define ST_CCW_BIT 5
`define ST_AUTO_BUSY_BIT 6
// ****************
// reset values
// ****************
`define JOG_SPEED_RST 32'h0000_0064
`define ACCEL_RST 32'h0000_000A
// ****************
// degree ring, milli-degree units
// ****************
`define DEG_FULL 32'sd360000
`define DEG_MAX 32'sd359999
`define DEG_SET_MAX 32'sd999999
`define DEG_ONE 32'sd1000
`define POS_W 19
// ****************
// timing
// ****************
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// [hdl/deg_setting_normalizer.v]
`timescale 1ns/1ns
`include "deg_jog_defines.vh"
// folds a signed milli-degree setting into 0..359999, registered output
module deg_setting_normalizer (
   input wire sys_clk, // clock
   input wire srst, // sync reset
   input wire [31:0] raw_val, // signed setting, hi:lo words joined
   output reg [18:0] norm_ff // normalised address
);
   reg [31:0] nxt_norm;
   wire signed [31:0] v = raw_val;
   always @* begin
      if (v >= 0 && v <= `DEG_MAX)
         nxt_norm = v;
      else if (v > `DEG_MAX && v <= `DEG_SET_MAX) begin
         // remainder of /360: at most two subtractions in this range
         if (v >= (`DEG_FULL + `DEG_FULL))
            nxt_norm = v - `DEG_FULL - `DEG_FULL;
         else
            nxt_norm = v - `DEG_FULL;
      end else if (v < 0 && v > -`DEG_FULL)
         nxt_norm = v + `DEG_FULL;
      else if (v <= -`DEG_FULL && v >= -`DEG_SET_MAX) begin
         // 360 plus the whole-degree quotient (-1 or -2)
         if (v <= -(`DEG_FULL + `DEG_FULL))
            nxt_norm = `DEG_FULL - `DEG_ONE - `DEG_ONE;
         else
            nxt_norm = `DEG_FULL - `DEG_ONE;
      end else if (v > 0)
         nxt_norm = `DEG_MAX;
      else
         nxt_norm = 32'h0000_0000;
   end
   always @(posedge sys_clk) begin
      if (srst)
         norm_ff <= 19'h0_0000;
      else
         norm_ff <= nxt_norm[18:0];
   end
endmodule // deg_setting_normalizer

// [hdl/degree_limits_and_jog_control.v]
`timescale 1ns/1ns
`include "deg_jog_defines.vh"
// How it works
// - pausing then leaving auto mode drops the remaining travel distance
// - current position wraps as a ring in degrees
// - software limits live in 0 to 359.999 degrees
// - out-of-range limit settings are folded back by modulo or offset, clamped to 359.999 or 0 beyond +/-999.999
// - motion allowed only on the ccw arc from minus to plus limit
// - equal minus and plus limits switch limit checking off
// - range output addresses are folded into 0 to 359.999 the same way
// - range output is the ccw arc from minus to plus address
// - mode select low means manual; table select inputs ignored then
// - jog uses jog speed and point one accel and decel
// - rotation direction setting swaps forward and reverse sense
// - forward start alone in manual starts jog
// - reverse start alone jogs opposite to forward
// - both starts on or both off stops jog
// - only four table number output points exist
// - pause decelerates in auto and a second press resumes remainder
// - pause input ignored during jog
module degree_limits_and_jog_control #(
   parameter TICK_CYCLES = `TICK_CYCLES // motion update period in clocks
) (
   input wire sys_clk, // 25 MHz clock
   input wire srst, // sync reset, active high
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp_ff, // write response
   output reg s_axi_bvalid_ff, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata_ff, // read data
   output reg [1:0] s_axi_rresp_ff, // read response
   output reg s_axi_rvalid_ff, // read data valid
   input wire s_axi_rready, // read data ready
   input wire pause_resume_in, // pause/resume request
   input wire op_mode_select_in, // high auto, low manual
   input wire forward_start_in, // forward start
   input wire reverse_start_in, // reverse start
   input wire table_select_bit0_in, // point select bit 0
   input wire table_select_bit1_in, // point select bit 1
   input wire table_select_bit2_in, // point select bit 2
   input wire table_select_bit3_in, // point select bit 3
   input wire table_select_bit4_in, // point select bit 4
   output reg table_number_bit0_out_ff, // active point bit 0
   output reg table_number_bit1_out_ff, // active point bit 1
   output reg table_number_bit2_out_ff, // active point bit 2
   output reg table_number_bit3_out_ff, // active point bit 3
   output reg [18:0] position_ff, // ring position, milli-degree
   output reg motor_ccw_ff, // motion direction, high ccw
   output reg [31:0] velocity_ff, // milli-degree per tick
   output reg range_out_ff // position inside range window
);
   // ****************
   // register file
   // ****************
   reg rot_dir_ff;
   reg [31:0] jog_speed_ff, pt1_acc_ff, pt1_dec_ff;
   reg signed [31:0] auto_dist_ff;
   reg [31:0] auto_speed_ff, auto_acc_ff, auto_dec_ff;
   reg [15:0] lim_ff [0:7];
   reg aw_hold_ff, w_hold_ff;
   reg [7:0] aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   wire [7:0] wr_addr = aw_hold_ff ? aw_addr_ff : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_ff ? w_data_ff : s_axi_wdata;
   wire [3:0] wr_strb = w_hold_ff ? w_strb_ff : s_axi_wstrb;
   wire aw_have = aw_hold_ff | s_axi_awvalid;
   wire w_have = w_hold_ff | s_axi_wvalid;
   wire wr_fire = aw_have & w_have & ~s_axi_bvalid_ff;
   wire wr_lim = (wr_addr >= `REG_LIMIT_BASE) && (wr_addr <= `REG_LIMIT_LAST);
   wire wr_ok = (wr_addr[1:0] == 2'b00) && (wr_lim || wr_addr <= `REG_AUTO_DECEL);
   assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid_ff;
   assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid_ff;
   assign s_axi_arready = ~s_axi_rvalid_ff;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   wire auto_start;
   always @(posedge sys_clk) begin
      if (srst) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_bvalid_ff <= 1'b0;
         s_axi_bresp_ff <= 2'b00;
         rot_dir_ff <= 1'b0;
         jog_speed_ff <= `JOG_SPEED_RST;
         pt1_acc_ff <= `ACCEL_RST;
         pt1_dec_ff <= `ACCEL_RST;
         auto_dist_ff <= 32'h0000_0000;
         auto_speed_ff <= `JOG_SPEED_RST;
         auto_acc_ff <= `ACCEL_RST;
         auto_dec_ff <= `ACCEL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
            w_hold_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_axi_bvalid_ff <= 1'b1;
            s_axi_bresp_ff <= wr_ok ? 2'b00 : 2'b10;
            case (wr_addr)
               `REG_CTRL: if (wr_strb[0]) rot_dir_ff <= wr_data[`CTRL_ROT_DIR_BIT];
               `REG_JOG_SPEED: jog_speed_ff <= merge(jog_speed_ff, wr_data, wr_strb);
               `REG_PT1_ACCEL: pt1_acc_ff <= merge(pt1_acc_ff, wr_data, wr_strb);
               `REG_PT1_DECEL: pt1_dec_ff <= merge(pt1_dec_ff, wr_data, wr_strb);
               `REG_AUTO_DIST: auto_dist_ff <= merge(auto_dist_ff, wr_data, wr_strb);
               `REG_AUTO_SPEED: auto_speed_ff <= merge(auto_speed_ff, wr_data, wr_strb);
               `REG_AUTO_ACCEL: auto_acc_ff <= merge(auto_acc_ff, wr_data, wr_strb);
               `REG_AUTO_DECEL: auto_dec_ff <= merge(auto_dec_ff, wr_data, wr_strb);
               default: ;
            endcase
         end else if (s_axi_bvalid_ff && s_axi_bready)
            s_axi_bvalid_ff <= 1'b0;
      end
   end

   // limit settings, eight 16-bit halves, one generate loop
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_lim
         always @(posedge sys_clk) begin
            if (srst)
               lim_ff[g] <= 16'h0000;
            else if (wr_fire && wr_lim && wr_addr[1:0] == 2'b00 && wr_addr[4:2] == g) begin
               if (wr_strb[0]) lim_ff[g][7:0] <= wr_data[7:0];
               if (wr_strb[1]) lim_ff[g][15:8] <= wr_data[15:8];
            end
         end
      end
   endgenerate

   // ****************
   // setting normalisation
   // ****************
   // order: soft plus, soft minus, range plus, range minus
   wire [18:0] norm [0:3];
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_norm
         deg_setting_normalizer u_norm (
            .sys_clk(sys_clk),
            .srst(srst),
            .raw_val({lim_ff[2*g+1], lim_ff[2*g]}),
            .norm_ff(norm[g])
         );
      end
   endgenerate

   function in_arc;
      input [18:0] p;
      input [18:0] lo;
      input [18:0] hi;
      begin
         // ccw arc from lo to hi, may straddle the zero point
         if (lo <= hi)
            in_arc = (p >= lo) && (p <= hi);
         else
            in_arc = (p >= lo) || (p <= hi);
      end
   endfunction

   wire lim_enable = (norm[1] != norm[0]);

   // ****************
   // inputs and mode
   // ****************
   reg pause_prev_ff, fwd_prev_ff, manual_prev_ff;
   wire manual = ~op_mode_select_in;
   wire jog_req = manual & (forward_start_in ^ reverse_start_in);
   // ccw when forward and setting 0; setting 1 swaps
   wire jog_ccw = forward_start_in ^ rot_dir_ff;
   wire pause_edge = pause_resume_in & ~pause_prev_ff;
   assign auto_start = ~manual & forward_start_in & ~fwd_prev_ff;

   reg paused_ff, auto_busy_ff, limit_hit_ff;
   reg [31:0] remain_ff;
   wire [4:0] tsel = {table_select_bit4_in, table_select_bit3_in, table_select_bit2_in,
                      table_select_bit1_in, table_select_bit0_in};

   // ****************
   // motion tick
   // ****************
   reg [14:0] tick_cnt_ff;
   wire tick = (tick_cnt_ff == TICK_CYCLES - 1);
   always @(posedge sys_clk) begin
      if (srst || tick)
         tick_cnt_ff <= 15'h0000;
      else
         tick_cnt_ff <= tick_cnt_ff + 15'h0001;
   end

   // ****************
   // velocity profile and ring position
   // ****************
   reg [31:0] tgt_vel, acc, dec, nxt_vel, step;
   reg [31:0] pos_sum;
   reg [18:0] nxt_pos;
   always @* begin
      if (manual) begin
         tgt_vel = jog_req ? jog_speed_ff : 32'h0000_0000;
         acc = pt1_acc_ff;
         dec = pt1_dec_ff;
      end else begin
         // a pause drives the target to zero with the auto decel setting
         tgt_vel = (auto_busy_ff && !paused_ff) ? auto_speed_ff : 32'h0000_0000;
         acc = auto_acc_ff;
         dec = auto_dec_ff;
      end
      // direction reversal in jog waits for standstill
      if (manual && jog_req && jog_ccw != motor_ccw_ff)
         tgt_vel = 32'h0000_0000;
      if (velocity_ff < tgt_vel)
         nxt_vel = (tgt_vel - velocity_ff > acc) ? velocity_ff + acc : tgt_vel;
      else
         nxt_vel = (velocity_ff - tgt_vel > dec) ? velocity_ff - dec : tgt_vel;
      step = nxt_vel;
      if (!manual && step > remain_ff)
         step = remain_ff;
      if (step > `DEG_MAX)
         step = `DEG_MAX;
      if (motor_ccw_ff) begin
         pos_sum = {13'h0000, position_ff} + step;
         if (pos_sum >= `DEG_FULL)
            pos_sum = pos_sum - `DEG_FULL;
      end else begin
         if ({13'h0000, position_ff} >= step)
            pos_sum = {13'h0000, position_ff} - step;
         else
            pos_sum = {13'h0000, position_ff} + `DEG_FULL - step;
      end
      nxt_pos = pos_sum[18:0];
   end

   wire blocked = lim_enable && step != 32'h0000_0000 &&
                  !in_arc(nxt_pos, norm[1], norm[0]);

   always @(posedge sys_clk) begin
      if (srst) begin
         pause_prev_ff <= 1'b0;
         fwd_prev_ff <= 1'b0;
         manual_prev_ff <= 1'b1;
         paused_ff <= 1'b0;
         auto_busy_ff <= 1'b0;
         limit_hit_ff <= 1'b0;
         remain_ff <= 32'h0000_0000;
         position_ff <= 19'h0_0000;
         motor_ccw_ff <= 1'b1;
         velocity_ff <= 32'h0000_0000;
         range_out_ff <= 1'b0;
         table_number_bit0_out_ff <= 1'b0;
         table_number_bit1_out_ff <= 1'b0;
         table_number_bit2_out_ff <= 1'b0;
         table_number_bit3_out_ff <= 1'b0;
      end else begin
         pause_prev_ff <= pause_resume_in;
         fwd_prev_ff <= forward_start_in;
         manual_prev_ff <= manual;
         range_out_ff <= in_arc(position_ff, norm[3], norm[2]);
         // pause is only honoured while an automatic move is under way
         if (pause_edge && !manual && auto_busy_ff)
            paused_ff <= ~paused_ff;
         if (manual && paused_ff) begin
            paused_ff <= 1'b0;
            auto_busy_ff <= 1'b0;
            remain_ff <= 32'h0000_0000;
         end
         // a start during a pause is refused
         if (auto_start && !auto_busy_ff && velocity_ff == 32'h0000_0000) begin
            auto_busy_ff <= auto_dist_ff != 32'h0000_0000;
            remain_ff <= auto_dist_ff[31] ? -auto_dist_ff : auto_dist_ff;
            motor_ccw_ff <= ~auto_dist_ff[31] ^ rot_dir_ff;
            limit_hit_ff <= 1'b0;
            // only four output points exist, the fifth select bit is not shown
            table_number_bit0_out_ff <= tsel[0];
            table_number_bit1_out_ff <= tsel[1];
            table_number_bit2_out_ff <= tsel[2];
            table_number_bit3_out_ff <= tsel[3];
         end
         if (manual && jog_req && velocity_ff == 32'h0000_0000) begin
            if (motor_ccw_ff != jog_ccw)
               limit_hit_ff <= 1'b0;
            motor_ccw_ff <= jog_ccw;
         end
         if (manual && !manual_prev_ff && !paused_ff && auto_busy_ff) begin
            // leaving auto without a pause also abandons the move
            auto_busy_ff <= 1'b0;
            remain_ff <= 32'h0000_0000;
         end
         if (tick) begin
            if (blocked) begin
               velocity_ff <= 32'h0000_0000;
               limit_hit_ff <= 1'b1;
            end else begin
               velocity_ff <= nxt_vel;
               position_ff <= nxt_pos;
               if (!manual && auto_busy_ff) begin
                  remain_ff <= remain_ff - step;
                  if (remain_ff == step) begin
                     auto_busy_ff <= 1'b0;
                     velocity_ff <= 32'h0000_0000;
                  end
               end
            end
         end
      end
   end

   // ****************
   // read channel
   // ****************
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_ok = (s_axi_araddr[1:0] == 2'b00);
      rd_val = 32'h0000_0000;
      if (s_axi_araddr >= `REG_LIMIT_BASE && s_axi_araddr <= `REG_LIMIT_LAST)
         rd_val = {16'h0000, lim_ff[s_axi_araddr[4:2]]};
      else begin
         case (s_axi_araddr)
            `REG_CTRL: rd_val = {31'h0000_0000, rot_dir_ff};
            `REG_JOG_SPEED: rd_val = jog_speed_ff;
            `REG_PT1_ACCEL: rd_val = pt1_acc_ff;
            `REG_PT1_DECEL: rd_val = pt1_dec_ff;
            `REG_AUTO_DIST: rd_val = auto_dist_ff;
            `REG_AUTO_SPEED: rd_val = auto_speed_ff;
            `REG_AUTO_ACCEL: rd_val = auto_acc_ff;
            `REG_AUTO_DECEL: rd_val = auto_dec_ff;
            `REG_STATUS: rd_val = {25'h000_0000, auto_busy_ff, motor_ccw_ff, manual,
                                   range_out_ff, limit_hit_ff, paused_ff,
                                   velocity_ff != 32'h0000_0000};
            `REG_POSITION: rd_val = {13'h0000, position_ff};
            `REG_REMAIN: rd_val = remain_ff;
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         s_axi_rvalid_ff <= 1'b0;
         s_axi_rdata_ff <= 32'h0000_0000;
         s_axi_rresp_ff <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid_ff <= 1'b1;
         s_axi_rdata_ff <= rd_ok ? rd_val : 32'h0000_0000;
         s_axi_rresp_ff <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid_ff && s_axi_rready)
         s_axi_rvalid_ff <= 1'b0;
   end
endmodule // degree_limits_and_jog_control

// [sim/deg_jog_chk.sv]
`timescale 1ns/1ns
// ****************
// port checker
// ****************
module deg_jog_chk (
   input wire sys_clk, // clock
   input wire srst, // sync reset
   input wire s_axi_awvalid, // aw valid
   input wire s_axi_awready, // aw ready
   input wire s_axi_wvalid, // w valid
   input wire s_axi_wready, // w ready
   input wire s_axi_bvalid_ff, // b valid
   input wire s_axi_bready, // b ready
   input wire s_axi_arvalid, // ar valid
   input wire s_axi_arready, // ar ready
   input wire s_axi_rvalid_ff, // r valid
   input wire s_axi_rready, // r ready
   input wire op_mode_select_in, // high auto
   input wire forward_start_in, // forward start
   input wire reverse_start_in, // reverse start
   input wire table_number_bit0_out_ff, // point bit 0
   input wire table_number_bit1_out_ff, // point bit 1
   input wire table_number_bit2_out_ff, // point bit 2
   input wire table_number_bit3_out_ff, // point bit 3
   input wire [18:0] position_ff, // ring position
   input wire [31:0] velocity_ff // speed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire jog_idle = !op_mode_select_in && (forward_start_in == reverse_start_in);
   wire [3:0] pt = {table_number_bit3_out_ff, table_number_bit2_out_ff,
      table_number_bit1_out_ff, table_number_bit0_out_ff};
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid_ff;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid_ff && !s_axi_bready |=> s_axi_bvalid_ff;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid_ff;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid_ff && !s_axi_rready |=> s_axi_rvalid_ff;
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
   property p_refuse;
      s_axi_bvalid_ff |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_refuse: assert property (p_refuse) else $error("write taken while answering");
   property p_ring;
      position_ff <= 19'd359999;
   endproperty
   a_ring: assert property (p_ring) else $error("position off the ring");
   // a stop request may only lower the speed, never raise it
   property p_jog_stop;
      jog_idle [*3] |=> velocity_ff <= $past(velocity_ff);
   endproperty
   a_jog_stop: assert property (p_jog_stop) else $error("jog speeds up while stopped");
   property p_standstill;
      (velocity_ff == 32'h0000_0000) [*2] |-> $stable(position_ff);
   endproperty
   a_standstill: assert property (p_standstill) else $error("position moves at rest");
   property p_table_hold;
      !op_mode_select_in && !$past(op_mode_select_in) |=> $stable(pt);
   endproperty
   a_table_hold: assert property (p_table_hold) else $error("point out changes in manual");
endmodule // deg_jog_chk

bind degree_limits_and_jog_control deg_jog_chk chk_u (.*);

// [sim/degree_limits_and_jog_control_tb.sv]
`timescale 1ns/1ns
module degree_limits_and_jog_control_tb;
   reg sys_clk = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   reg [7:0] awa = 8'h00, ara = 8'h00;
   reg [31:0] wd = 32'h0000_0000, rd;
   reg [1:0] resp;
   reg auto_req = 0, fwd_req = 0, rev_req = 0, pause_req = 0;
   reg [4:0] sel_req = 5'h00;
   wire awr, wr, arr, bv, rv, pr, om, fs, rs, t0, t1, t2, t3, ccw, rout;
   wire [1:0] br, rr;
   wire [31:0] rdat, vel;
   wire [18:0] pos;
   wire [4:0] ts;
   int n_mismatch = 0, tests_run = 0, i, v;
   int vals[8] = '{360000, 720000, 0, -360000, -1, 999999, -400000, 1200000};
   always #20 sys_clk = ~sys_clk;
   host_io_model host_u (.sys_clk, .srst, .auto_req, .fwd_req, .rev_req, .pause_req, .sel_req,
      .pause_resume_in(pr), .op_mode_select_in(om), .forward_start_in(fs),
      .reverse_start_in(rs), .table_select_in(ts));
   degree_limits_and_jog_control #(.TICK_CYCLES(4)) dut_u (.sys_clk, .srst,
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp_ff(br),
      .s_axi_bvalid_ff(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata_ff(rdat), .s_axi_rresp_ff(rr),
      .s_axi_rvalid_ff(rv), .s_axi_rready(rre), .pause_resume_in(pr),
      .op_mode_select_in(om), .forward_start_in(fs), .reverse_start_in(rs),
      .table_select_bit0_in(ts[0]), .table_select_bit1_in(ts[1]),
      .table_select_bit2_in(ts[2]), .table_select_bit3_in(ts[3]),
      .table_select_bit4_in(ts[4]), .table_number_bit0_out_ff(t0),
      .table_number_bit1_out_ff(t1), .table_number_bit2_out_ff(t2),
      .table_number_bit3_out_ff(t3), .position_ff(pos), .motor_ccw_ff(ccw),
      .velocity_ff(vel), .range_out_ff(rout));
   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task give_up;
      n_mismatch++;
      end_sim;
   endtask
   task axi_wr(input [7:0] a, input [31:0] d);
      int k;
      @(posedge sys_clk);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
         if (bv) break;
      end
      if (k == 50) give_up;
      resp = br;
      bre <= 0;
   endtask
   task axi_rd(input [7:0] a);
      int k;
      @(posedge sys_clk);
      ara <= a; arv <= 1; rre <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      if (k == 50) give_up;
      rd = rdat; resp = rr;
      rre <= 0;
   endtask
   // hi:lo word pair of a signed milli-degree setting
   task set_pair(input [7:0] a, input [31:0] d);
      axi_wr(a, {16'h0000, d[15:0]});
      axi_wr(a + 8'h04, {16'h0000, d[31:16]});
   endtask
   task host(input a, input f, input r, input p);
      @(posedge sys_clk);
      auto_req <= a; fwd_req <= f; rev_req <= r; pause_req <= p;
   endtask
   task wait_vel(input bit moving);
      int k;
      for (k = 0; k < 800 && ((vel !== 32'h0000_0000) != moving); k++) @(posedge sys_clk);
      if (k == 800) give_up;
   endtask
   function automatic [18:0] norm_deg(input int x);
      if (x > 999999) norm_deg = 19'd359999;
      else if (x < -999999) norm_deg = 19'd0;
      else if (x >= 360000) norm_deg = 19'(x % 360000);
      else if (x >= 0) norm_deg = 19'(x);
      else if (x > -360000) norm_deg = 19'(x + 360000);
      else norm_deg = 19'(360000 + (x / 360000) * 1000);
   endfunction
   initial begin
      i = $urandom(32'h41c9);
      repeat (6) @(posedge sys_clk);
      srst <= 0;
      axi_rd(8'h04);
      chk("jog speed reset", rd, 32'h0000_0064);
      axi_rd(8'h80);
      chk("unmapped rresp", {30'h0, resp}, 32'h0000_0002);
      axi_wr(8'h82, 32'h0000_1234);
      chk("unmapped bresp", {30'h0, resp}, 32'h0000_0002);
      // one-point range window, axis at 0
      for (i = 0; i < 14; i++) begin
         v = (i < 8) ? vals[i] : int'($urandom_range(1999998)) - 999999;
         set_pair(8'h38, v);
         set_pair(8'h30, v);
         repeat (3) @(posedge sys_clk);
         chk("range out", {31'h0, rout}, {31'h0, norm_deg(v) == 19'd0});
      end
      set_pair(8'h28, 0);
      set_pair(8'h20, 5000);
      host(0, 0, 1, 0);
      repeat (60) @(posedge sys_clk);
      chk("pos at limit", {13'h0, pos}, 32'h0000_0000);
      axi_rd(8'h40);
      chk("limit flag", {31'h0, rd[2]}, 32'h0000_0001);
      host(0, 0, 0, 0);
      wait_vel(0);
      set_pair(8'h28, 7000);
      set_pair(8'h20, 7000);
      host(0, 1, 0, 0);
      wait_vel(1);
      repeat (8) @(posedge sys_clk);
      chk("fwd ccw", {31'h0, ccw}, 32'h0000_0001);
      host(0, 1, 1, 0);
      wait_vel(0);
      host(0, 0, 1, 0);
      wait_vel(1);
      host(0, 0, 1, 1);
      repeat (12) @(posedge sys_clk);
      chk("pause in jog", {31'h0, vel == 32'h0000_0000}, 32'h0000_0000);
      chk("rev cw", {31'h0, ccw}, 32'h0000_0000);
      for (i = 0; i < 3000 && pos < 19'd180000; i++) @(posedge sys_clk);
      chk("wrap cw", {31'h0, pos > 19'd180000}, 32'h0000_0001);
      host(0, 0, 0, 0);
      wait_vel(0);
      axi_wr(8'h00, 32'h0000_0001);
      host(0, 1, 0, 0);
      wait_vel(1);
      repeat (8) @(posedge sys_clk);
      chk("swapped fwd", {31'h0, ccw}, 32'h0000_0000);
      host(0, 0, 0, 0);
      wait_vel(0);
      sel_req <= 5'($urandom_range(31, 1));
      host(0, 1, 0, 0);
      repeat (6) @(posedge sys_clk);
      chk("pt out manual", {28'h0, t3, t2, t1, t0}, 32'h0000_0000);
      host(0, 0, 0, 0);
      wait_vel(0);
      axi_wr(8'h10, 32'h0000_C350);
      host(1, 0, 0, 0);
      host(1, 1, 0, 0);
      wait_vel(1);
      chk("pt out auto", {28'h0, t3, t2, t1, t0}, {28'h0, sel_req[3:0]});
      host(1, 0, 0, 1);
      wait_vel(0);
      axi_rd(8'h48);
      chk("remain kept", {31'h0, rd == 32'h0000_0000}, 32'h0000_0000);
      host(0, 0, 0, 0);
      repeat (4) @(posedge sys_clk);
      axi_rd(8'h48);
      chk("remain cleared", rd, 32'h0000_0000);
      end_sim;
   end
endmodule // degree_limits_and_jog_control_tb

// [sim/host_io_model.sv]
`timescale 1ns/1ns
// ****************
// host driving the discrete inputs
// ****************
module host_io_model (
   input wire sys_clk, // clock
   input wire srst, // sync reset
   input wire auto_req, // wants auto mode
   input wire fwd_req, // wants forward start
   input wire rev_req, // wants reverse start
   input wire pause_req, // wants pause pressed
   input wire [4:0] sel_req, // wanted point
   output reg pause_resume_in, // pause/resume
   output reg op_mode_select_in, // high auto
   output reg forward_start_in, // forward start
   output reg reverse_start_in, // reverse start
   output reg [4:0] table_select_in // point select
);
   // no homing: the ring position is never lost here
   always @(posedge sys_clk) begin
      if (srst) begin
         pause_resume_in <= 1'b0;
         op_mode_select_in <= 1'b0;
         forward_start_in <= 1'b0;
         reverse_start_in <= 1'b0;
         table_select_in <= 5'h00;
      end else begin
         // leaving auto is only asked after a pause has stopped the axis
         op_mode_select_in <= auto_req;
         pause_resume_in <= pause_req;
         forward_start_in <= fwd_req;
         reverse_start_in <= rev_req;
         table_select_in <= sel_req;
      end
   end
endmodule // host_io_model
